// [design/civu_pkg.sv]
// civu_pkg: constants, codes and state layout of the interrupt vectoring unit
// assumes one system clock shared with the fifo, protocol and host-link logic
package civu_pkg;

	localparam int unsigned FIFO_N = 32;
	localparam int unsigned MODE_W = 3;

	// interrupt_enable_and_flags bit positions
	localparam int unsigned B_BAD_MSG_EN = 31;
	localparam int unsigned B_WAKE_EN = 30;
	localparam int unsigned B_BUS_ERR_EN = 29;
	localparam int unsigned B_SYS_ERR_EN = 28;
	localparam int unsigned B_RX_OVF_EN = 27;
	localparam int unsigned B_TX_ATT_EN = 26;
	localparam int unsigned B_CRC_EN = 25;
	localparam int unsigned B_ECC_EN = 24;
	localparam int unsigned B_TEF_EN = 20;
	localparam int unsigned B_MODE_EN = 19;
	localparam int unsigned B_TBC_EN = 18;
	localparam int unsigned B_RX_EN = 17;
	localparam int unsigned B_TX_EN = 16;
	localparam int unsigned B_BAD_MSG = 15;
	localparam int unsigned B_WAKE = 14;
	localparam int unsigned B_BUS_ERR = 13;
	localparam int unsigned B_SYS_ERR = 12;
	localparam int unsigned B_RX_OVF = 11;
	localparam int unsigned B_TX_ATT = 10;
	localparam int unsigned B_CRC = 9;
	localparam int unsigned B_ECC = 8;
	localparam int unsigned B_TEF = 4;
	localparam int unsigned B_MODE = 3;
	localparam int unsigned B_TBC = 2;
	localparam int unsigned B_RX = 1;
	localparam int unsigned B_TX = 0;

	// writable enables: bits 31..24 and 20..16
	localparam logic [31:0] ENABLE_MASK = 32'hFF1F0000;
	localparam logic [31:0] INT_RESET = 32'h00000000;

	// pending_source_code values
	localparam logic [6:0] CODE_TX_ATT = 7'h4A;
	localparam logic [6:0] CODE_TEF = 7'h49;
	localparam logic [6:0] CODE_BAD_MSG = 7'h48;
	localparam logic [6:0] CODE_MODE = 7'h47;
	localparam logic [6:0] CODE_TBC = 7'h46;
	localparam logic [6:0] CODE_MAB = 7'h45;
	localparam logic [6:0] CODE_ADDR = 7'h44;
	localparam logic [6:0] CODE_RX_OVF = 7'h43;
	localparam logic [6:0] CODE_WAKE = 7'h42;
	localparam logic [6:0] CODE_BUS_ERR = 7'h41;
	localparam logic [6:0] CODE_NONE = 7'h40;
	localparam logic [6:0] CODE_TXQ = 7'h00;
	localparam logic [31:0] VEC_RESET = 32'h00000040;

	typedef struct packed {
		logic [31:0] enables;
		logic bad_message_flag;
		logic bus_wake_flag;
		logic bus_error_flag;
		logic system_error_flag;
		logic mab_fault_seen;
		logic addr_fault_seen;
		logic mode_change_flag;
		logic time_base_wrap_flag;
		logic [MODE_W-1:0] mode_prev;
		logic mode_seen;
		logic [FIFO_N-1:0] rx_pend;
		logic [FIFO_N-1:0] tx_pend;
		logic [31:0] int_word;
		logic [31:0] vec_word;
		logic irq;
	} civu_state_t;

	// one-cycle event pulses from the protocol engine and friends
	typedef struct packed {
		logic bad_message;
		logic bus_wake;
		logic bus_error;
		logic mab_fault;
		logic addr_fault;
		logic time_base_wrap;
	} civu_events_t;

endpackage

// [design/civu_vector_unit.sv]
// civu_vector_unit: interrupt collection, flag register and vector code
// assumes all inputs come from logic on clk; host-link writes arrive as a
// one-cycle strobe with data, and both registers are read from the outputs
//
// Functional notes
// - vector bits 6-0 hold code; 1000000 when idle; reserved codes never shown
// - several pending sources: highest numeric code is reported
// - code 1001010 while any attempt status bit set and attempt enable set
// - code 1001001 while any transmit event queue status bit set
// - code 1001000 for bad message flag with its enable
// - code 1000111 for mode change flag with its enable
// - code 1000110 for time base wrap flag with its enable
// - system errors: 1000101 for buffer over/underflow, 1000100 for address error
// - code 1000011 while any receive overflow status bit set
// - code 1000010 for bus wake flag with its enable
// - code 1000001 for bus error flag with its enable
// - fifo n pending gives code n; transmit queue pending gives 0000000
// - enables at bits 31..24, read/write, zero at reset
// - enables at bits 20..16, read/write, zero at reset
// - hardware sets bits 15,14,13,12,3,2; software clears them by writing
// - bit 11 reads one while any receive overflow is pending
// - bit 4 reads one while a transmit event queue interrupt pends
// - bit 1 shows receive fifo pending, bit 0 transmit fifo pending
// - mode change flag sets whenever operating mode field changes
// - time base wrap flag sets when the 32-bit counter wraps
// - system error flag sets on any system error
// - bits 23-21, 7-5 and vector bit 7 read zero
// - per-fifo pending is or of enabled flags, clears when condition ends
`timescale 1ns/10ps
`default_nettype none

module civu_vector_unit (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic int_wr_stb,
	input wire logic [31:0] int_wr_data,
	input wire civu_pkg::civu_events_t events,
	input wire logic [civu_pkg::MODE_W-1:0] operating_mode_field,
	input wire logic host_link_crc_flag,
	input wire logic ram_ecc_flag,
	input wire logic [civu_pkg::FIFO_N-1:0] rx_fifo_raw,
	input wire logic [civu_pkg::FIFO_N-1:0] rx_fifo_raw_en,
	input wire logic [civu_pkg::FIFO_N-1:0] tx_fifo_raw,
	input wire logic [civu_pkg::FIFO_N-1:0] tx_fifo_raw_en,
	input wire logic [civu_pkg::FIFO_N-1:0] per_fifo_overrun_pending,
	input wire logic [civu_pkg::FIFO_N-1:0] per_fifo_attempt_pending,
	input wire logic [civu_pkg::FIFO_N-1:0] tx_event_queue_status,
	output logic [31:0] interrupt_enable_and_flags,
	output logic [31:0] interrupt_vector_code,
	output logic [civu_pkg::FIFO_N-1:0] per_fifo_rx_pending,
	output logic [civu_pkg::FIFO_N-1:0] per_fifo_tx_pending,
	output logic irq
);

	civu_pkg::civu_state_t state_r;
	civu_pkg::civu_state_t state_nxt;

	logic [31:0] en;
	logic [civu_pkg::FIFO_N-1:0] rx_p;
	logic [civu_pkg::FIFO_N-1:0] tx_p;
	logic [civu_pkg::FIFO_N-1:0] fifo_any;
	logic rx_ovf_sum;
	logic tx_att_sum;
	logic tef_sum;
	logic [6:0] code;
	logic [31:0] iw;

	always_comb
	begin
		state_nxt = state_r;

		// receive fifo 0 cannot receive, so its pending bit stays low
		rx_p = rx_fifo_raw & rx_fifo_raw_en;
		rx_p[0] = 1'b0;
		tx_p = tx_fifo_raw & tx_fifo_raw_en;
		state_nxt.rx_pend = rx_p;
		state_nxt.tx_pend = tx_p;

		if (int_wr_stb)
		begin
			state_nxt.enables = int_wr_data & civu_pkg::ENABLE_MASK;
			// written-zero clears; written-one leaves the flag alone
			state_nxt.bad_message_flag = state_r.bad_message_flag
				& int_wr_data[civu_pkg::B_BAD_MSG];
			state_nxt.bus_wake_flag = state_r.bus_wake_flag & int_wr_data[civu_pkg::B_WAKE];
			state_nxt.bus_error_flag = state_r.bus_error_flag
				& int_wr_data[civu_pkg::B_BUS_ERR];
			state_nxt.system_error_flag = state_r.system_error_flag
				& int_wr_data[civu_pkg::B_SYS_ERR];
			state_nxt.mode_change_flag = state_r.mode_change_flag
				& int_wr_data[civu_pkg::B_MODE];
			state_nxt.time_base_wrap_flag = state_r.time_base_wrap_flag
				& int_wr_data[civu_pkg::B_TBC];
			// the cause of a system error goes with the flag
			state_nxt.mab_fault_seen = state_r.mab_fault_seen & int_wr_data[civu_pkg::B_SYS_ERR];
			state_nxt.addr_fault_seen = state_r.addr_fault_seen
				& int_wr_data[civu_pkg::B_SYS_ERR];
		end
		// vector must follow the enables being written, as the flag word does
		en = state_nxt.enables;

		// sets are applied after clears so an event in a clearing cycle survives
		if (events.bad_message)
			state_nxt.bad_message_flag = 1'b1;
		if (events.bus_wake)
			state_nxt.bus_wake_flag = 1'b1;
		if (events.bus_error)
			state_nxt.bus_error_flag = 1'b1;
		if (events.mab_fault)
			state_nxt.mab_fault_seen = 1'b1;
		if (events.addr_fault)
			state_nxt.addr_fault_seen = 1'b1;
		if (events.mab_fault || events.addr_fault)
			state_nxt.system_error_flag = 1'b1;
		if (events.time_base_wrap)
			state_nxt.time_base_wrap_flag = 1'b1;
		// no flag on the first sample after reset: there is nothing to compare with
		if (state_r.mode_seen && (operating_mode_field != state_r.mode_prev))
			state_nxt.mode_change_flag = 1'b1;
		state_nxt.mode_prev = operating_mode_field;
		state_nxt.mode_seen = 1'b1;

		rx_ovf_sum = |per_fifo_overrun_pending;
		tx_att_sum = |per_fifo_attempt_pending;
		tef_sum = |tx_event_queue_status;

		// vector from the flag values being registered this cycle
		fifo_any = rx_p | tx_p;
		code = civu_pkg::CODE_NONE;
		for (int i = 1; i < civu_pkg::FIFO_N; i++)
		begin
			if (fifo_any[i])
				code = 7'(i);
		end
		if ((code == civu_pkg::CODE_NONE) && tx_p[0])
			code = civu_pkg::CODE_TXQ;
		// later lines override earlier, so the highest code wins
		if (state_nxt.bus_error_flag && en[civu_pkg::B_BUS_ERR_EN])
			code = civu_pkg::CODE_BUS_ERR;
		if (state_nxt.bus_wake_flag && en[civu_pkg::B_WAKE_EN])
			code = civu_pkg::CODE_WAKE;
		if (rx_ovf_sum)
			code = civu_pkg::CODE_RX_OVF;
		if (state_nxt.addr_fault_seen && state_nxt.system_error_flag
			&& en[civu_pkg::B_SYS_ERR_EN])
			code = civu_pkg::CODE_ADDR;
		if (state_nxt.mab_fault_seen && state_nxt.system_error_flag
			&& en[civu_pkg::B_SYS_ERR_EN])
			code = civu_pkg::CODE_MAB;
		if (state_nxt.time_base_wrap_flag && en[civu_pkg::B_TBC_EN])
			code = civu_pkg::CODE_TBC;
		if (state_nxt.mode_change_flag && en[civu_pkg::B_MODE_EN])
			code = civu_pkg::CODE_MODE;
		if (state_nxt.bad_message_flag && en[civu_pkg::B_BAD_MSG_EN])
			code = civu_pkg::CODE_BAD_MSG;
		if (tef_sum)
			code = civu_pkg::CODE_TEF;
		if (tx_att_sum && en[civu_pkg::B_TX_ATT_EN])
			code = civu_pkg::CODE_TX_ATT;
		state_nxt.vec_word = {25'h0000000, code};

		// assembled word; unimplemented bits stay zero
		iw = state_nxt.enables;
		iw[civu_pkg::B_BAD_MSG] = state_nxt.bad_message_flag;
		iw[civu_pkg::B_WAKE] = state_nxt.bus_wake_flag;
		iw[civu_pkg::B_BUS_ERR] = state_nxt.bus_error_flag;
		iw[civu_pkg::B_SYS_ERR] = state_nxt.system_error_flag;
		iw[civu_pkg::B_RX_OVF] = rx_ovf_sum;
		iw[civu_pkg::B_TX_ATT] = tx_att_sum;
		iw[civu_pkg::B_CRC] = host_link_crc_flag;
		iw[civu_pkg::B_ECC] = ram_ecc_flag;
		iw[civu_pkg::B_TEF] = tef_sum;
		iw[civu_pkg::B_MODE] = state_nxt.mode_change_flag;
		iw[civu_pkg::B_TBC] = state_nxt.time_base_wrap_flag;
		iw[civu_pkg::B_RX] = |rx_p;
		iw[civu_pkg::B_TX] = |tx_p;
		state_nxt.int_word = iw;
		// enables sit exactly 16 bits above their flags
		state_nxt.irq = |(iw[15:0] & iw[31:16]);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_r <= '0;
			state_r.enables <= civu_pkg::INT_RESET;
			state_r.int_word <= civu_pkg::INT_RESET;
			state_r.vec_word <= civu_pkg::VEC_RESET;
		end
		else if (ce)
			state_r <= state_nxt;
	end

	assign interrupt_enable_and_flags = state_r.int_word;
	assign interrupt_vector_code = state_r.vec_word;
	assign per_fifo_rx_pending = state_r.rx_pend;
	assign per_fifo_tx_pending = state_r.tx_pend;
	assign irq = state_r.irq;

endmodule

`default_nettype wire

// [sim/civu_vector_unit_chk.sv]
// civu_vector_unit_chk: port-level assertions for the vector unit
// assumes one clk domain with synchronous active-high rst
`timescale 1ns/10ps
`default_nettype none
module civu_vector_unit_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic int_wr_stb,
	input wire logic [31:0] int_wr_data,
	input wire civu_pkg::civu_events_t events,
	input wire logic [31:0] interrupt_enable_and_flags,
	input wire logic [31:0] interrupt_vector_code,
	input wire logic [civu_pkg::FIFO_N-1:0] per_fifo_rx_pending,
	input wire logic [civu_pkg::FIFO_N-1:0] per_fifo_tx_pending,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire logic go = ce && !rst;
	wire logic [31:0] iw = interrupt_enable_and_flags;
	wire logic [31:0] vc = interrupt_vector_code;
	a_vec_upper_zero: assert property (vc[31:7] == 25'h0)
		else $error("vector upper bits set");
	a_no_reserved: assert property (vc[6:0] <= 7'h4A && vc[6:5] != 2'h1)
		else $error("reserved code shown");
	a_unimpl_zero: assert property (iw[23:21] == 3'h0 && iw[7:5] == 3'h0)
		else $error("unimplemented bits set");
	a_bus_err_set: assert property (go && events.bus_error |=> iw[13])
		else $error("bus error flag not set");
	a_irq_match: assert property (irq == |(iw[15:0] & iw[31:16]))
		else $error("irq disagrees with flags");
	a_fifo_summary: assert property (iw[1] == |per_fifo_rx_pending[31:1]
		&& iw[0] == |per_fifo_tx_pending) else $error("fifo summary wrong");
	a_flag_clear: assert property (go && int_wr_stb && !int_wr_data[13]
		&& !events.bus_error |=> !iw[13]) else $error("flag not cleared");
	a_enable_write: assert property (go && int_wr_stb
		|=> (iw & civu_pkg::ENABLE_MASK) == ($past(int_wr_data) & civu_pkg::ENABLE_MASK))
		else $error("enables wrong");
endmodule
bind civu_vector_unit civu_vector_unit_chk chk (.clk(clk), .rst(rst), .ce(ce),
	.int_wr_stb(int_wr_stb), .int_wr_data(int_wr_data), .events(events),
	.interrupt_enable_and_flags(interrupt_enable_and_flags),
	.interrupt_vector_code(interrupt_vector_code), .per_fifo_rx_pending(per_fifo_rx_pending),
	.per_fifo_tx_pending(per_fifo_tx_pending), .irq(irq));
`default_nettype wire

// [sim/civu_host_model.sv]
// civu_host_model: host software writing the interrupt register
// assumes the bench clock; drives at the falling edge
`timescale 1ns/10ps
`default_nettype none
module civu_host_model (
	input wire logic clk,
	output logic int_wr_stb,
	output logic [31:0] int_wr_data
);
	initial
	begin
		int_wr_stb = 1'b0;
		int_wr_data = 32'h00000000;
	end
	// flags cleared only by writing zero; fifo pending left to fifo side
	task automatic write_word(input logic [31:0] w);
		@(negedge clk);
		int_wr_stb = 1'b1;
		int_wr_data = w;
		@(negedge clk);
		int_wr_stb = 1'b0;
		int_wr_data = ~w;
	endtask
endmodule
`default_nettype wire

// [sim/test_can_fd_interrupt_vector_unit.sv]
// test_can_fd_interrupt_vector_unit: self-checking bench for the vector unit
// assumes the host model for writes; bench drives levels at the falling edge
`timescale 1ns/10ps
`default_nettype none
module test_can_fd_interrupt_vector_unit;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic crc = 1'b0;
	logic ecc = 1'b0;
	logic ce = 1'b1;
	logic [2:0] mode = 3'h0;
	civu_pkg::civu_events_t ev = 6'h00;
	logic [31:0] rxr, rxe, txr, txe, ovr, att, transmit_event_queue, iw, vc, rxp, txp, wd;
	logic irq, stb;
	int err_count = 0;
	int num_checks = 0;
	always #25 clk = ~clk;
	civu_host_model host (.clk(clk), .int_wr_stb(stb), .int_wr_data(wd));
	civu_vector_unit dut (.clk(clk), .rst(rst), .ce(ce), .int_wr_stb(stb), .int_wr_data(wd),
		.events(ev), .operating_mode_field(mode), .host_link_crc_flag(crc), .ram_ecc_flag(ecc),
		.rx_fifo_raw(rxr), .rx_fifo_raw_en(rxe), .tx_fifo_raw(txr), .tx_fifo_raw_en(txe),
		.per_fifo_overrun_pending(ovr), .per_fifo_attempt_pending(att),
		.tx_event_queue_status(transmit_event_queue), .interrupt_enable_and_flags(iw),
		.interrupt_vector_code(vc), .per_fifo_rx_pending(rxp), .per_fifo_tx_pending(txp), .irq(irq));
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic pulse(input civu_pkg::civu_events_t e);
		@(negedge clk);
		ev = e;
		@(negedge clk);
		ev = 6'h00;
	endtask
	// keeps every enable, clears one flag
	task automatic clr(input int b);
		host.write_word({16'hFF1F, ~(16'h0001 << b)});
	endtask
	task automatic t_events();
		host.write_word(32'hFFFFFFFF);
		chk("int", iw, 32'hFF1F0000);
		pulse(6'h38);
		chk("vec", vc, 32'h00000048);
		chk("int", iw, 32'hFF1FE000);
		chk("irq", {31'h0, irq}, 32'h00000001);
		clr(15);
		chk("vec", vc, 32'h00000042);
		clr(14);
		chk("vec", vc, 32'h00000041);
		clr(13);
		chk("vec", vc, 32'h00000040);
		pulse(6'h04);
		chk("int", iw, 32'hFF1F1000);
		chk("vec", vc, 32'h00000045);
		clr(12);
		pulse(6'h02);
		chk("vec", vc, 32'h00000044);
		clr(12);
		pulse(6'h01);
		chk("vec", vc, 32'h00000046);
		mode = 3'h5;
		@(negedge clk);
		chk("vec", vc, 32'h00000047);
		// drop the wrap enable, keep its flag: vector and request follow at once
		host.write_word(32'hFF1B0004);
		chk("int", iw, 32'hFF1B0004);
		chk("vec", vc, 32'h00000040);
		chk("irq", {31'h0, irq}, 32'h00000000);
		host.write_word(32'hFF1F0000);
		chk("int", iw, 32'hFF1F0000);
	endtask
	task automatic t_levels();
		ovr = 32'h00000020;
		crc = 1'b1;
		ecc = 1'b1;
		@(negedge clk);
		chk("vec", vc, 32'h00000043);
		chk("int", iw, 32'hFF1F0B00);
		chk("irq", {31'h0, irq}, 32'h00000001);
		transmit_event_queue = 32'h80000000;
		@(negedge clk);
		chk("vec", vc, 32'h00000049);
		att = 32'h00000001;
		@(negedge clk);
		chk("vec", vc, 32'h0000004A);
		// clock enable low: sources drop but every output must hold
		ce = 1'b0;
		{ovr, att, transmit_event_queue} = 96'h0;
		@(negedge clk);
		chk("vec", vc, 32'h0000004A);
		chk("int", iw, 32'hFF1F0F10);
		ce = 1'b1;
		crc = 1'b0;
		ecc = 1'b0;
		rxr = 32'h00000081;
		txr = 32'h80000001;
		@(negedge clk);
		chk("vec", vc, 32'h0000001F);
		chk("rxp", rxp & 32'hFFFFFFFE, 32'h00000080);
		chk("txp", txp, 32'h80000001);
		chk("int", iw, 32'hFF1F0003);
		{rxr, txr} = 64'h0000000000000001;
		@(negedge clk);
		chk("vec", vc, 32'h00000000);
		txe = 32'h00000000;
		@(negedge clk);
		chk("vec", vc, 32'h00000040);
	endtask
	task automatic conclude();
		if (err_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		{rxr, txr, ovr, att, transmit_event_queue} = 160'h0;
		{rxe, txe} = 64'hFFFFFFFFFFFFFFFF;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		chk("vec", vc, 32'h00000040);
		chk("int", iw, 32'h00000000);
		t_events();
		t_levels();
		conclude();
	end
	// far beyond the few dozen cycles the scenarios need
	initial
	begin
		#200000;
		err_count++;
		conclude();
	end
endmodule
`default_nettype wire
